// ==== rtl/cmdcrc_regs.svh ====
// timing-free constants for the command and identification crc block
`ifndef CMDCRC_REGS_SVH
`define CMDCRC_REGS_SVH
`define CMDCRC_POLY16 16'ha001
`define CMDCRC_POLY8 8'h8c
`define CMDCRC_CLEAR16 16'h0000
`define CMDCRC_CLEAR8 8'h00
`define CMDCRC_LAST_OFS 5'h1f
`define CMDCRC_HIDDEN_BYTE 8'hff
`define CMDCRC_ID_CRC_MSB 63
`define CMDCRC_ID_CRC_LSB 56
`endif

// ==== rtl/cmdcrc_pkg.sv ====
// types shared by the command and identification crc block
`default_nettype none
package cmdcrc_pkg;
    typedef enum logic [2:0] {
        CMDCRC_SRC_CMD = 3'b000,
        CMDCRC_SRC_ADDR = 3'b001,
        CMDCRC_SRC_STATUS = 3'b010,
        CMDCRC_SRC_DATA = 3'b011,
        CMDCRC_SRC_COUNTER = 3'b100,
        CMDCRC_SRC_CONTROL = 3'b101
    } cmdcrc_src_t;
    typedef enum logic [1:0] {
        CMDCRC_OP_WRITE_PAD = 2'b00,
        CMDCRC_OP_READ_PAD = 2'b01,
        CMDCRC_OP_AUTH_READ = 2'b10,
        CMDCRC_OP_HASH = 2'b11
    } cmdcrc_op_t;
endpackage : cmdcrc_pkg
`default_nettype wire

// ==== rtl/cmdcrc_core.sv ====
// crc16 transaction checker and crc8 identification byte for a single-wire token
// Notes on behaviour
// - top identification byte is a fixed crc over the lower seven bytes
// - identification crc uses x^8+x^5+x^4+1
// - identification crc byte goes out true, not inverted
// - transaction crc is crc16 x^16+x^15+x^2+1 for four commands
// - transmitted crc16 is always the complement of the generator
// - scratchpad write: clear, then command, both addresses, all data
// - scratchpad write returns crc only if offset 11111b was written
// - write may start anywhere; crc same whatever the concealed flag
// - concealed flag set: written data feeds crc only, never stored
// - scratchpad read: clear, command, addresses, status, data from offset
// - read crc sent only when reading runs through the scratchpad end
// - concealed flag set: read crc takes ffh in place of data
// - authenticated read: command, addresses, data, page and secret counters
// - counters enter the crc least significant byte first
// - hash command crc: command, both addresses, control byte, from clear
`timescale 1ns/100ps
`default_nettype none
`include "cmdcrc_regs.svh"
module cmdcrc_core #(
    parameter logic [55:0] ID_BODY = 56'h00_0000_0000_0001
)(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic crc_clear,
    input wire cmdcrc_pkg::cmdcrc_op_t op,
    input wire logic byte_valid,
    input wire logic [7:0] byte_in,
    input wire cmdcrc_pkg::cmdcrc_src_t byte_src,
    input wire logic [4:0] pad_offset,
    input wire logic concealed_scratchpad_flag,
    input wire logic txn_end,
    output logic pad_store,
    output logic [63:0] id_number,
    output logic [15:0] crc_out,
    output logic crc_send,
    output logic [15:0] crc_state
);
    logic [15:0] crc_r;
    logic [7:0] id_crc_r;
    logic [15:0] crc_out_r;
    logic crc_send_r;
    logic reached_end_r;
    logic [7:0] feed_byte;

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] v;
        v = c;
        for (int i = 0; i < 8; i++)
        begin
            // lsb first, reflected form
            v = (v[0] ^ d[i]) ? ((v >> 1) ^ `CMDCRC_POLY16) : (v >> 1);
        end
        return v;
    endfunction : crc16_byte

    function automatic logic [7:0] crc8_bytes(input logic [55:0] d);
        logic [7:0] v;
        v = `CMDCRC_CLEAR8;
        for (int i = 0; i < 56; i++)
        begin
            v = (v[0] ^ d[i]) ? ((v >> 1) ^ `CMDCRC_POLY8) : (v >> 1);
        end
        return v;
    endfunction : crc8_bytes

    // concealed read data replaced by all ones
    always_comb
    begin
        feed_byte = byte_in;
        if (op == cmdcrc_pkg::CMDCRC_OP_READ_PAD && byte_src == cmdcrc_pkg::CMDCRC_SRC_DATA
            && concealed_scratchpad_flag)
        begin
            feed_byte = `CMDCRC_HIDDEN_BYTE;
        end
    end

    // write data stored only when not concealed
    assign pad_store = clk_en && byte_valid && op == cmdcrc_pkg::CMDCRC_OP_WRITE_PAD
        && byte_src == cmdcrc_pkg::CMDCRC_SRC_DATA && !concealed_scratchpad_flag;

    // identification crc computed at reset release, held fixed
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            id_crc_r <= `CMDCRC_CLEAR8;
        end
        else if (clk_en)
        begin
            id_crc_r <= crc8_bytes(ID_BODY);
        end
    end
    assign id_number = {id_crc_r, ID_BODY}; // true form

    // generator; caller orders bytes, counters lsb first
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            crc_r <= `CMDCRC_CLEAR16;
        end
        else if (clk_en)
        begin
            if (crc_clear)
            begin
                crc_r <= `CMDCRC_CLEAR16;
            end
            else if (byte_valid)
            begin
                crc_r <= crc16_byte(crc_r, feed_byte);
            end
        end
    end
    assign crc_state = crc_r;

    // tracks whether the last scratchpad offset was covered
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            reached_end_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (crc_clear)
            begin
                reached_end_r <= 1'b0;
            end
            else if (byte_valid && byte_src == cmdcrc_pkg::CMDCRC_SRC_DATA
                && pad_offset == `CMDCRC_LAST_OFS)
            begin
                reached_end_r <= 1'b1;
            end
        end
    end

    // complemented result at transaction end
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            crc_out_r <= 16'h0000;
            crc_send_r <= 1'b0;
        end
        else if (clk_en)
        begin
            crc_send_r <= 1'b0;
            if (txn_end)
            begin
                crc_out_r <= ~crc_r;
                unique case (op)
                    cmdcrc_pkg::CMDCRC_OP_WRITE_PAD,
                    cmdcrc_pkg::CMDCRC_OP_READ_PAD: crc_send_r <= reached_end_r;
                    cmdcrc_pkg::CMDCRC_OP_AUTH_READ,
                    cmdcrc_pkg::CMDCRC_OP_HASH: crc_send_r <= 1'b1;
                endcase
            end
        end
    end
    assign crc_out = crc_out_r;
    assign crc_send = crc_send_r;

    a_crc_inverted: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && txn_end |=> crc_out == ~$past(crc_r))
        else $error("sent crc is not the complement");
    a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && crc_clear |=> crc_r == 16'h0000)
        else $error("clear did not zero the generator");
    a_pad_send_gate: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && txn_end && op inside {cmdcrc_pkg::CMDCRC_OP_WRITE_PAD,
        cmdcrc_pkg::CMDCRC_OP_READ_PAD} && !reached_end_r |=> !crc_send)
        else $error("crc sent without reaching last offset");
    a_hidden_no_store: assert property (@(posedge sys_clk) disable iff (reset)
        concealed_scratchpad_flag |-> !pad_store)
        else $error("concealed data was stored");
    a_hidden_ones: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && concealed_scratchpad_flag
        && op == cmdcrc_pkg::CMDCRC_OP_READ_PAD && byte_src == cmdcrc_pkg::CMDCRC_SRC_DATA
        |=> crc_r == crc16_byte($past(crc_r), 8'hff))
        else $error("concealed read did not feed ffh");
    a_id_true_form: assert property (@(posedge sys_clk) disable iff (reset)
        $past(clk_en) && !$past(reset) |-> id_number[63:56] == crc8_bytes(ID_BODY))
        else $error("identification crc byte wrong");
    a_auth_sends: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && txn_end && op == cmdcrc_pkg::CMDCRC_OP_AUTH_READ |=> crc_send)
        else $error("authenticated read crc not sent");
    a_hash_sends: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && txn_end && op == cmdcrc_pkg::CMDCRC_OP_HASH |=> crc_send)
        else $error("hash crc not sent");

    // generator stepping, freezing and clearing; result freezing, send pulse and holding
    a_freeze_crc: assert property (@(posedge sys_clk) disable iff (reset)
        !clk_en |=> $stable(crc_r))
        else $error("generator moved while frozen");
    a_freeze_out: assert property (@(posedge sys_clk) disable iff (reset)
        !clk_en |=> $stable(crc_out) && $stable(crc_send))
        else $error("result moved while frozen");
    a_send_pulse: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !txn_end |=> !crc_send)
        else $error("crc send without transaction end");
    a_out_holds: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !txn_end |=> $stable(crc_out))
        else $error("sent crc changed between transactions");
    a_feed_step: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear
        |=> crc_r == crc16_byte($past(crc_r), $past(feed_byte)))
        else $error("generator did not take the fed byte");
    a_clear_wins: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && crc_clear && byte_valid |=> crc_r == `CMDCRC_CLEAR16)
        else $error("byte fed during clear");
    a_idle_holds: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !crc_clear && !byte_valid |=> $stable(crc_r))
        else $error("generator moved without a byte");
    a_cmd_feed: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && byte_src == cmdcrc_pkg::CMDCRC_SRC_CMD
        |=> crc_r == crc16_byte($past(crc_r), $past(byte_in)))
        else $error("command byte not fed as sent");
    a_addr_feed: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && byte_src == cmdcrc_pkg::CMDCRC_SRC_ADDR
        |=> crc_r == crc16_byte($past(crc_r), $past(byte_in)))
        else $error("address byte not fed as sent");
    a_status_feed: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && byte_src == cmdcrc_pkg::CMDCRC_SRC_STATUS
        |=> crc_r == crc16_byte($past(crc_r), $past(byte_in)))
        else $error("status byte not fed as sent");
    a_counter_feed: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && byte_src == cmdcrc_pkg::CMDCRC_SRC_COUNTER
        |=> crc_r == crc16_byte($past(crc_r), $past(byte_in)))
        else $error("counter byte not fed as sent");
    a_control_feed: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && byte_src == cmdcrc_pkg::CMDCRC_SRC_CONTROL
        |=> crc_r == crc16_byte($past(crc_r), $past(byte_in)))
        else $error("control byte not fed as sent");
    a_write_feed_true: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && op == cmdcrc_pkg::CMDCRC_OP_WRITE_PAD
        |=> crc_r == crc16_byte($past(crc_r), $past(byte_in)))
        else $error("write data not fed as received");
    a_plain_read_feed: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && !concealed_scratchpad_flag
        && op == cmdcrc_pkg::CMDCRC_OP_READ_PAD
        |=> crc_r == crc16_byte($past(crc_r), $past(byte_in)))
        else $error("visible read data not fed");

    // scratchpad store and end-of-pad tracking
    a_write_store: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && op == cmdcrc_pkg::CMDCRC_OP_WRITE_PAD
        && byte_src == cmdcrc_pkg::CMDCRC_SRC_DATA && !concealed_scratchpad_flag
        |-> pad_store)
        else $error("visible write data not stored");
    a_read_no_store: assert property (@(posedge sys_clk) disable iff (reset)
        op != cmdcrc_pkg::CMDCRC_OP_WRITE_PAD |-> !pad_store)
        else $error("store outside a scratchpad write");
    a_end_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && byte_valid && !crc_clear && byte_src == cmdcrc_pkg::CMDCRC_SRC_DATA
        && pad_offset == `CMDCRC_LAST_OFS |=> reached_end_r)
        else $error("last offset not noted");
    a_end_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && crc_clear |=> !reached_end_r)
        else $error("end flag survived a clear");
    a_pad_sends_full: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && txn_end && op inside {cmdcrc_pkg::CMDCRC_OP_WRITE_PAD,
        cmdcrc_pkg::CMDCRC_OP_READ_PAD} && reached_end_r |=> crc_send)
        else $error("crc withheld after last offset");

    // reset state
    a_id_reset_zero: assert property (@(posedge sys_clk)
        reset |=> id_number[63:56] == `CMDCRC_CLEAR8)
        else $error("identification crc not cleared by reset");
    a_reset_quiet: assert property (@(posedge sys_clk)
        reset |=> crc_state == `CMDCRC_CLEAR16 && !crc_send && crc_out == 16'h0000)
        else $error("reset left generator or result set");

    c_write_full: cover property (@(posedge sys_clk)
        op == cmdcrc_pkg::CMDCRC_OP_WRITE_PAD && crc_send);
    c_read_hidden: cover property (@(posedge sys_clk)
        op == cmdcrc_pkg::CMDCRC_OP_READ_PAD && concealed_scratchpad_flag && crc_send);
    c_auth_read: cover property (@(posedge sys_clk)
        op == cmdcrc_pkg::CMDCRC_OP_AUTH_READ && crc_send);
    c_hash_sent: cover property (@(posedge sys_clk)
        op == cmdcrc_pkg::CMDCRC_OP_HASH && crc_send);
    c_write_short: cover property (@(posedge sys_clk)
        op == cmdcrc_pkg::CMDCRC_OP_WRITE_PAD && txn_end && !reached_end_r);
endmodule : cmdcrc_core
`default_nettype wire

// ==== tb/cmdcrc_master_model.sv ====
// bus master model: recomputes crc16 and identification crc8
`timescale 1ns/100ps
`default_nettype none
module cmdcrc_master_model (
    input wire logic sys_clk,
    input wire logic m_clear,
    input wire logic m_feed,
    input wire logic [7:0] m_byte,
    input wire logic [63:0] id_seen,
    output logic [15:0] m_crc,
    output logic id_ok
);
    logic [7:0] c8;
    function automatic logic [15:0] step16(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        return c;
    endfunction : step16
    always_ff @(posedge sys_clk)
    begin
        if (m_clear)
            m_crc <= 16'h0000;
        else if (m_feed)
            m_crc <= step16(m_crc, m_byte);
    end
    always_comb
    begin
        c8 = 8'h00;
        for (int i = 0; i < 56; i++)
            c8 = (c8[0] ^ id_seen[i]) ? ((c8 >> 1) ^ 8'h8c) : (c8 >> 1);
        id_ok = (c8 == id_seen[63:56]);
    end
endmodule : cmdcrc_master_model
`default_nettype wire

// ==== tb/cmdcrc_core_tb_top.sv ====
// self-checking bench for the command and identification crc block
`timescale 1ns/100ps
`default_nettype none
module cmdcrc_core_tb_top;
    logic sys_clk = 0, reset = 1, clk_en = 1, crc_clear = 0, byte_valid = 0, txn_end = 0;
    logic concealed_scratchpad_flag = 0, m_clear = 0, m_feed = 0, pad_store, crc_send, id_ok;
    logic [7:0] byte_in = 8'h00, m_byte = 8'h00;
    logic [4:0] pad_offset = 5'h00, st;
    logic [3:0] nd;
    logic [1:0] opv;
    logic hd, snd;
    logic [15:0] crc_out, crc_state, m_crc, held;
    logic [63:0] id_number;
    cmdcrc_pkg::cmdcrc_op_t op = cmdcrc_pkg::CMDCRC_OP_WRITE_PAD;
    cmdcrc_pkg::cmdcrc_src_t byte_src = cmdcrc_pkg::CMDCRC_SRC_CMD;
    int err_total = 0, comparisons = 0;
    // op, start offset, data count, concealed, crc expected
    logic [12:0] rows [7] = '{{2'h0, 5'h1c, 4'h4, 1'h0, 1'h1}, {2'h0, 5'h00, 4'h3, 1'h1, 1'h0},
        {2'h0, 5'h1e, 4'h2, 1'h1, 1'h1}, {2'h1, 5'h1d, 4'h3, 1'h1, 1'h1},
        {2'h1, 5'h00, 4'h2, 1'h0, 1'h0}, {2'h2, 5'h00, 4'h4, 1'h0, 1'h1},
        {2'h3, 5'h00, 4'h0, 1'h0, 1'h1}};
    always #10 sys_clk = ~sys_clk;
    cmdcrc_core cmdcrc_core_inst (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .crc_clear(crc_clear), .op(op), .byte_valid(byte_valid), .byte_in(byte_in),
        .byte_src(byte_src), .pad_offset(pad_offset),
        .concealed_scratchpad_flag(concealed_scratchpad_flag), .txn_end(txn_end),
        .pad_store(pad_store), .id_number(id_number), .crc_out(crc_out),
        .crc_send(crc_send), .crc_state(crc_state));
    cmdcrc_master_model cmdcrc_master_model_inst (.sys_clk(sys_clk), .m_clear(m_clear),
        .m_feed(m_feed), .m_byte(m_byte), .id_seen(id_number), .m_crc(m_crc), .id_ok(id_ok));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic put(input cmdcrc_pkg::cmdcrc_src_t s, input logic [7:0] b, input logic w);
        @(negedge sys_clk);
        byte_valid = 1'b1;
        byte_src = s;
        byte_in = b;
        m_feed = 1'b1;
        m_byte = (s == cmdcrc_pkg::CMDCRC_SRC_DATA && opv == 2'h1 && hd) ? 8'hff : b;
        #1;
        if (w)
            chk("pad_store", {15'h0000, pad_store}, {15'h0000, !hd});
        @(negedge sys_clk);
        byte_valid = 1'b0;
        m_feed = 1'b0;
    endtask : put
    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        #200000;
        err_total++;
        complete_run();
    end
    initial
    begin
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        chk("crc_send", {15'h0000, crc_send}, 16'h0000);
        chk("crc_out", crc_out, 16'h0000);
        @(negedge sys_clk);
        chk("id_crc", {15'h0000, id_ok}, 16'h0001);
        for (int r = 0; r < 7; r++)
        begin
            {opv, st, nd, hd, snd} = rows[r];
            op = cmdcrc_pkg::cmdcrc_op_t'(opv);
            concealed_scratchpad_flag = hd;
            crc_clear = 1'b1;
            m_clear = 1'b1;
            @(negedge sys_clk);
            crc_clear = 1'b0;
            m_clear = 1'b0;
            chk("crc_state", crc_state, 16'h0000);
            put(cmdcrc_pkg::CMDCRC_SRC_CMD, 8'h0f + 8'(r), 1'b0);
            put(cmdcrc_pkg::CMDCRC_SRC_ADDR, {3'h0, st}, 1'b0);
            put(cmdcrc_pkg::CMDCRC_SRC_ADDR, 8'h01, 1'b0);
            if (opv == 2'h1)
                put(cmdcrc_pkg::CMDCRC_SRC_STATUS, 8'h1f, 1'b0);
            for (int k = 0; k < nd; k++)
            begin
                pad_offset = st + 5'(k);
                put(cmdcrc_pkg::CMDCRC_SRC_DATA, 8'h40 + 8'(r * 8 + k), opv == 2'h0);
            end
            if (opv == 2'h2)
                for (int k = 0; k < 8; k++)
                    put(cmdcrc_pkg::CMDCRC_SRC_COUNTER, 8'h90 + 8'(k), 1'b0);
            if (opv == 2'h3)
                put(cmdcrc_pkg::CMDCRC_SRC_CONTROL, 8'h33, 1'b0);
            chk("crc_state", crc_state, m_crc);
            @(negedge sys_clk);
            txn_end = 1'b1;
            @(negedge sys_clk);
            txn_end = 1'b0;
            chk("crc_send", {15'h0000, crc_send}, {15'h0000, snd});
            chk("crc_out", crc_out, ~m_crc);
        end
        held = crc_state;
        clk_en = 1'b0;
        put(cmdcrc_pkg::CMDCRC_SRC_DATA, 8'h5a, 1'b0);
        chk("crc_state", crc_state, held);
        clk_en = 1'b1;
        // clear and byte in one cycle: clear wins
        @(negedge sys_clk);
        crc_clear = 1'b1;
        byte_valid = 1'b1;
        byte_src = cmdcrc_pkg::CMDCRC_SRC_CMD;
        byte_in = 8'h5a;
        @(negedge sys_clk);
        crc_clear = 1'b0;
        byte_valid = 1'b0;
        chk("crc_state", crc_state, 16'h0000);
        // mid-run reset with a busy generator
        put(cmdcrc_pkg::CMDCRC_SRC_CMD, 8'h0f, 1'b0);
        reset = 1'b1;
        @(negedge sys_clk);
        chk("crc_state", crc_state, 16'h0000);
        chk("crc_send", {15'h0000, crc_send}, 16'h0000);
        chk("crc_out", crc_out, 16'h0000);
        chk("id_crc_reset", {8'h00, id_number[63:56]}, 16'h0000);
        reset = 1'b0;
        @(negedge sys_clk);
        chk("id_crc", {15'h0000, id_ok}, 16'h0001);
        complete_run();
    end
endmodule : cmdcrc_core_tb_top
`default_nettype wire
